// *** bench/sdb_checker.sv ***
`include "sdb_defs.vh"
module sdb_checker (
	input wire CLK_IN,
	input wire RESET_N_IN,
	input wire WB_CYC_IN,
	input wire WB_STB_IN,
	input wire WB_WE_IN,
	input wire [7:0] WB_ADR_IN,
	input wire [31:0] WB_DAT_IN,
	input wire WB_ACK_OUT,
	input wire ACC_REQ_IN,
	input wire [31:0] ACC_ADDR_IN,
	input wire ACC_WE_IN,
	input wire [5:0] ACC_TYPE_IN,
	input wire ACC_READY_OUT,
	input wire [1:0] ACC_HIT_OUT,
	input wire CS_HIT_IN,
	input wire EXT_ACK_IN,
	input wire EXT_CYC_OUT,
	input wire ADDR_EXC_OUT,
	input wire ACC_EXC_OUT,
	input wire SD_DQ_OE_N_OUT,
	input wire [1:0] SD_CS_N_OUT,
	input wire SD_ROW_STROBE_N_OUT,
	input wire COLUMN_STROBE_N_OUT,
	input wire SD_WE_N_OUT,
	input wire [31:0] SD_ADDR_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	logic [31:0] c0_q, m0_q;
	logic [7:0] ext_n_q;
	logic acked_q;
	wire take = ACC_REQ_IN && ACC_READY_OUT;
	wire wb_wr = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_WE_IN;
	wire [2:0] cmd = SD_CS_N_OUT[0] ? `SDB_CMD_NOP :
		{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT};
	// Only fully masked bases are judged, so no compare model is needed here
	wire blk0 = m0_q[0] && (&m0_q[31:18]) && !(|(ACC_TYPE_IN & m0_q[6:1]));
	// Shadow assumes full-word writes
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			c0_q <= 32'h0;
			m0_q <= 32'h0;
		end else if (wb_wr && WB_ADR_IN == `SDB_OFS_CTRL0) begin
			c0_q <= WB_DAT_IN;
		end else if (wb_wr && WB_ADR_IN == `SDB_OFS_MASK0) begin
			m0_q <= WB_DAT_IN;
		end
	end
	// Length of the external cycle, and whether its acknowledge was seen
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ext_n_q <= 8'h00;
			acked_q <= 1'b0;
		end else begin
			ext_n_q <= EXT_CYC_OUT ? ext_n_q + 8'h01 : 8'h00;
			acked_q <= EXT_CYC_OUT && (acked_q || EXT_ACK_IN);
		end
	end
	property p_hit;
		take && blk0 |=> ACC_HIT_OUT[0];
	endproperty
	property p_novalid;
		take && !m0_q[0] |=> !ACC_HIT_OUT[0];
	endproperty
	property p_type;
		take && m0_q[0] && (|(ACC_TYPE_IN & m0_q[6:1])) |=> !ACC_HIT_OUT[0];
	endproperty
	property p_wp;
		take && blk0 && ACC_WE_IN && m0_q[8] |=> ADDR_EXC_OUT;
	endproperty
	property p_quiet;
		take && blk0 && ACC_WE_IN && m0_q[8] |=> (SD_CS_N_OUT == 2'h3) [*3];
	endproperty
	property p_ext;
		$fell(EXT_CYC_OUT) && !acked_q |-> ACC_EXC_OUT && ext_n_q == `SDB_EXT_TIMEOUT;
	endproperty
	property p_extack;
		$fell(EXT_CYC_OUT) && acked_q |-> !ACC_EXC_OUT;
	endproperty
	property p_mrs;
		take |-> ##2 (cmd != `SDB_CMD_MRS || SD_ADDR_OUT == $past(ACC_ADDR_IN, 2));
	endproperty
	property p_oe;
		!SD_CS_N_OUT[0] |-> SD_DQ_OE_N_OUT == (cmd != `SDB_CMD_WRITE);
	endproperty
	property p_close;
		cmd == `SDB_CMD_ACT && !c0_q[2] |-> ##[2:20] cmd == `SDB_CMD_PRECHARGE_ALL_CMD;
	endproperty
	a_hit: assert property (p_hit) else $error("masked hit missing");
	a_novalid: assert property (p_novalid) else $error("hit while invalid");
	a_type: assert property (p_type) else $error("masked type hit");
	a_wp: assert property (p_wp) else $error("no address exception");
	a_quiet: assert property (p_quiet) else $error("command on refused write");
	a_ext: assert property (p_ext) else $error("no access exception");
	a_extack: assert property (p_extack) else $error("exception after acknowledge");
	a_mrs: assert property (p_mrs) else $error("mode value wrong");
	a_oe: assert property (p_oe) else $error("data lanes driven off a write");
	a_close: assert property (p_close) else $error("page left open");
	c_mrs: cover property (cmd == `SDB_CMD_MRS);
	c_precharge_all_cmd: cover property (cmd == `SDB_CMD_PRECHARGE_ALL_CMD);
	c_exc: cover property (ACC_EXC_OUT);
endmodule
bind sdb_ctrl sdb_checker chk (.*);

// *** bench/sdb_ctrl_tb.sv ***
`include "sdb_defs.vh"
module sdb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_IN = 0, RESET_N_IN = 0, WB_CYC_IN = 0, WB_STB_IN = 0, WB_WE_IN = 0;
	logic ACC_REQ_IN = 0, ACC_WE_IN = 0, CS_HIT_IN = 0, EXT_ACK_IN = 0;
	logic [7:0] WB_ADR_IN = 0;
	logic [3:0] WB_SEL_IN = 4'hF;
	logic [31:0] WB_DAT_IN = 0, ACC_ADDR_IN = 0, WB_DAT_OUT, SD_ADDR_OUT, q;
	logic [1:0] ACC_SIZE_IN = 0, ACC_HIT_OUT, SD_CS_N_OUT;
	logic [5:0] ACC_TYPE_IN = 0;
	logic WB_ACK_OUT, IRQ_OUT, ACC_READY_OUT, ACC_DONE_OUT, EXT_CYC_OUT, ADDR_EXC_OUT;
	logic ACC_EXC_OUT, SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT, SD_DQ_OE_N_OUT;
	logic ea, ec;
	int err_total, compares, cycles, n_cmd[8], b[8];
	sdb_ctrl dut (.*);
	sdb_sdram_model mem (.CLK_IN(CLK_IN), .cs_n_in(SD_CS_N_OUT[0]),
		.cmd_in({SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT}), .n_cmd(n_cmd));
	initial begin
		forever #5 CLK_IN = ~CLK_IN;
	end
	always @(posedge CLK_IN) begin
		cycles++;
		if (cycles > 5000) begin
			err_total++;
			print_verdict;
		end
	end
	task automatic print_verdict;
		$display("counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	function automatic logic [31:0] cmds(input int k);
		return 32'(n_cmd[k] - b[k]);
	endfunction
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		WB_CYC_IN <= 1'b1;
		WB_STB_IN <= 1'b1;
		WB_WE_IN <= we;
		WB_ADR_IN <= a;
		WB_DAT_IN <= d;
		do @(posedge CLK_IN); while (WB_ACK_OUT !== 1'b1);
		q = WB_DAT_OUT;
		WB_CYC_IN <= 1'b0;
		WB_STB_IN <= 1'b0;
		@(posedge CLK_IN);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic acc(input logic [31:0] a, input logic we, input logic [1:0] sz,
		input logic [5:0] ty);
		b = n_cmd;
		ea = 0;
		ec = 0;
		ACC_REQ_IN <= 1'b1;
		ACC_ADDR_IN <= a;
		ACC_WE_IN <= we;
		ACC_SIZE_IN <= sz;
		ACC_TYPE_IN <= ty;
		do @(posedge CLK_IN); while (ACC_READY_OUT !== 1'b1);
		ACC_REQ_IN <= 1'b0;
		do begin
			@(posedge CLK_IN);
			ea = ea | ADDR_EXC_OUT;
			ec = ec | ACC_EXC_OUT;
		end while (ACC_DONE_OUT !== 1'b1);
		// One more edge lets the command tally of the final beat land
		@(posedge CLK_IN);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 6; i++)
			rd(8'(4 * i), 32'h0);
		wb(1'b1, `SDB_OFS_CTRL1, 32'hFFFFFFFF);
		rd(`SDB_OFS_CTRL1, `SDB_CTRL_WMASK);
		wb(1'b1, `SDB_OFS_MASK1, 32'hFFFFFFFF);
		rd(`SDB_OFS_MASK1, `SDB_MASK_WMASK);
		wb(1'b1, `SDB_OFS_MASK1, 32'h0);
		WB_SEL_IN <= 4'h1;
		wb(1'b1, `SDB_OFS_CTRL1, 32'h0);
		WB_SEL_IN <= 4'hF;
		rd(`SDB_OFS_CTRL1, `SDB_CTRL_WMASK & 32'hFFFFFF00);
		wb(1'b1, 8'h18, 32'hFFFFFFFF);
		rd(8'h18, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_precharge_all_cmd;
		wb(1'b1, `SDB_OFS_CTRL0, 32'h20);
		wb(1'b1, `SDB_OFS_MASK0, 32'hFFFC0001);
		wb(1'b1, `SDB_OFS_CTRL0, 32'h28);
		acc(32'h40, 1'b1, 2'h1, 6'h01);
		chk(cmds(`SDB_CMD_PRECHARGE_ALL_CMD), 1);
		rd(`SDB_OFS_CTRL0, 32'h20);
		chk(IRQ_OUT, 0);
		wb(1'b1, `SDB_OFS_IRQ_MASK, 32'hF);
		chk(IRQ_OUT, 1);
		rd(`SDB_OFS_IRQ_STAT, 32'h2);
		chk(IRQ_OUT, 0);
		$display("t_precharge_all_cmd done");
	endtask
	task automatic t_mrs;
		wb(1'b1, `SDB_OFS_CTRL0, 32'h60);
		acc(32'h33, 1'b1, 2'h2, 6'h01);
		chk(cmds(`SDB_CMD_MRS), 1);
		chk(cmds(`SDB_CMD_WRITE), 0);
		chk(SD_ADDR_OUT, 32'h33);
		rd(`SDB_OFS_CTRL0, 32'h20);
		chk(IRQ_OUT, 1);
		rd(`SDB_OFS_IRQ_STAT, 32'h1);
		$display("t_mrs done");
	endtask
	task automatic t_burst;
		for (int w = 1; w <= 2; w++) begin
			wb(1'b1, `SDB_OFS_CTRL0, w == 1 ? 32'h20 : 32'h10);
			acc(32'h100, 1'b1, 2'h2, 6'h01);
			chk(cmds(`SDB_CMD_ACT), 1);
			chk(cmds(`SDB_CMD_WRITE), 2 * w);
			chk(cmds(`SDB_CMD_PRECHARGE_ALL_CMD), 1);
		end
		wb(1'b1, `SDB_OFS_CTRL0, 32'h20);
		acc(32'h100, 1'b0, 2'h3, 6'h01);
		chk(cmds(`SDB_CMD_READ), 8);
		chk(cmds(`SDB_CMD_PRECHARGE_ALL_CMD), 1);
		$display("t_burst done");
	endtask
	task automatic t_page;
		wb(1'b1, `SDB_OFS_CTRL0, 32'h24);
		acc(32'h200, 1'b0, 2'h1, 6'h01);
		acc(32'h202, 1'b0, 2'h1, 6'h01);
		chk(cmds(`SDB_CMD_ACT) + cmds(`SDB_CMD_PRECHARGE_ALL_CMD), 0);
		chk(cmds(`SDB_CMD_READ), 1);
		$display("t_page done");
	endtask
	task automatic t_prot;
		logic [31:0] mk [3] = '{32'h0, 32'h1, 32'h40001};
		logic [1:0] ex [3] = '{2'h0, 2'h0, 2'h1};
		wb(1'b1, `SDB_OFS_MASK0, 32'hFFFC0101);
		CS_HIT_IN <= 1'b1;
		acc(32'h300, 1'b1, 2'h1, 6'h01);
		chk({ea, ec}, 2'h2);
		chk(cmds(`SDB_CMD_WRITE) + cmds(`SDB_CMD_ACT), 0);
		CS_HIT_IN <= 1'b0;
		acc(32'h300, 1'b1, 2'h1, 6'h01);
		chk({ea, ec, EXT_CYC_OUT}, 3'h6);
		rd(`SDB_OFS_IRQ_STAT, 32'hC);
		EXT_ACK_IN <= 1'b1;
		acc(32'h300, 1'b1, 2'h1, 6'h01);
		EXT_ACK_IN <= 1'b0;
		chk({ea, ec, EXT_CYC_OUT}, 3'h4);
		rd(`SDB_OFS_IRQ_STAT, 32'h4);
		acc(32'h300, 1'b0, 2'h1, 6'h01);
		chk(ACC_HIT_OUT, 2'h1);
		for (int k = 0; k < 6; k++) begin
			wb(1'b1, `SDB_OFS_MASK0, 32'hFFFC0001 | (32'h2 << k));
			acc(32'h0, 1'b0, 2'h1, 6'(1 << k));
			chk(ACC_HIT_OUT, 2'h0);
			acc(32'h0, 1'b0, 2'h1, 6'(1 << ((k + 1) % 6)));
			chk(ACC_HIT_OUT, 2'h1);
		end
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, `SDB_OFS_MASK0, mk[i]);
			acc(32'h40000, 1'b0, 2'h1, 6'h01);
			chk(ACC_HIT_OUT, ex[i]);
		end
		$display("t_prot done");
	endtask
	initial begin
		repeat (20) @(posedge CLK_IN);
		RESET_N_IN <= 1'b1;
		@(posedge CLK_IN);
		t_regs;
		t_precharge_all_cmd;
		t_mrs;
		t_burst;
		t_page;
		t_prot;
		print_verdict;
	end
endmodule

// *** bench/sdb_sdram_model.sv ***
// Tallies commands only; data lanes are not ported, so no storage is kept
module sdb_sdram_model (
	input wire CLK_IN,
	input wire cs_n_in,
	input wire [2:0] cmd_in,
	output int n_cmd[8]
);
	timeunit 1ns;
	timeprecision 1ns;
	initial n_cmd = '{default: 0};
	always @(posedge CLK_IN) begin
		if (!cs_n_in)
			n_cmd[cmd_in] <= n_cmd[cmd_in] + 1;
	end
endmodule

// *** hw/sdb_ctrl.v ***
// Implementation choices: register access over Wishbone and the register addresses.
`include "sdb_defs.vh"
module sdb_ctrl #(
	parameter PAGE_LSB = 9,
	parameter PAGE_MSB = 23
) (
	input wire CLK_IN,
	input wire RESET_N_IN,
	input wire WB_CYC_IN,
	input wire WB_STB_IN,
	input wire WB_WE_IN,
	input wire [7:0] WB_ADR_IN,
	input wire [3:0] WB_SEL_IN,
	input wire [31:0] WB_DAT_IN,
	output reg [31:0] WB_DAT_OUT,
	output reg WB_ACK_OUT,
	output wire IRQ_OUT,
	input wire ACC_REQ_IN,
	input wire [31:0] ACC_ADDR_IN,
	input wire ACC_WE_IN,
	input wire [1:0] ACC_SIZE_IN,
	input wire [5:0] ACC_TYPE_IN,
	output wire ACC_READY_OUT,
	output reg ACC_DONE_OUT,
	output reg [1:0] ACC_HIT_OUT,
	input wire CS_HIT_IN,
	input wire EXT_ACK_IN,
	output reg EXT_CYC_OUT,
	output reg ADDR_EXC_OUT,
	output reg ACC_EXC_OUT,
	output reg [1:0] SD_CS_N_OUT,
	output reg SD_ROW_STROBE_N_OUT,
	output reg COLUMN_STROBE_N_OUT,
	output reg SD_WE_N_OUT,
	output reg [31:0] SD_ADDR_OUT,
	output reg SD_DQ_OE_N_OUT
);
	localparam S_IDLE = 3'h0;
	localparam S_ACT = 3'h1;
	localparam S_XFER = 3'h2;
	localparam S_PRE = 3'h3;
	localparam S_CMD = 3'h4;
	localparam S_EXT = 3'h5;
	localparam S_OPEN = 3'h6;
	localparam PW = PAGE_MSB - PAGE_LSB + 1;

	reg [31:0] ctrl_q [0:1];
	reg [31:0] mask_q [0:1];
	reg [3:0] irq_stat_q;
	reg [3:0] irq_mask_q;
	reg [2:0] state_q;
	reg blk_q;
	reg we_q;
	reg [4:0] beats_q;
	reg [31:0] addr_q;
	reg [2:0] addr_step_q;
	reg cmd_mrs_q;
	reg close_then_open_q;
	reg [1:0] open_q;
	reg [PW-1:0] row_q [0:1];
	reg [7:0] ext_cnt_q;
	reg ext_ack_s1_q;
	reg ext_ack_s2_q;
	reg mrs_done_q;
	reg precharge_all_cmd_done_q;
	reg addr_exc_q;
	reg acc_exc_q;

	wire [1:0] hit;
	wire wb_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
	wire wb_wr = wb_req & WB_WE_IN;
	wire wb_rd = wb_req & ~WB_WE_IN;
	wire [31:0] sel_mask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
		{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
	wire take = ACC_REQ_IN & (state_q == S_IDLE);
	wire hblk = ~hit[0];
	wire [31:0] hctrl = ctrl_q[hblk];
	wire [31:0] hmask = mask_q[hblk];
	wire [31:0] cctrl = ctrl_q[blk_q];
	wire port16 = cctrl[`SDB_CTRL_PWS_HI];
	wire [PW-1:0] acc_row = ACC_ADDR_IN[PAGE_MSB:PAGE_LSB];
	reg [4:0] acc_bytes;
	reg [4:0] acc_beats;

	assign ACC_READY_OUT = (state_q == S_IDLE);
	assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_blk
			wire [13:0] base = ctrl_q[g][`SDB_CTRL_BASE_HI:`SDB_CTRL_BASE_LO];
			wire [13:0] bmask = mask_q[g][`SDB_MASK_BASE_HI:`SDB_MASK_BASE_LO];
			wire amatch = &(~(base ^ ACC_ADDR_IN[31:18]) | bmask);
			wire tblock = |(ACC_TYPE_IN & mask_q[g][`SDB_MASK_TYPE_HI:`SDB_MASK_TYPE_LO]);
			assign hit[g] = mask_q[g][`SDB_MASK_VALID] & amatch & ~tblock;
		end
	endgenerate

	// Transfer size over port width gives the burst length
	always @* begin
		acc_bytes = 5'h01;
		case (ACC_SIZE_IN)
			2'h0: acc_bytes = 5'h01;
			2'h1: acc_bytes = 5'h02;
			2'h2: acc_bytes = 5'h04;
			default: acc_bytes = 5'h10;
		endcase
		if (hctrl[`SDB_CTRL_PWS_HI]) begin
			acc_beats = (acc_bytes > 5'h01) ? {1'b0, acc_bytes[4:1]} : 5'h01;
		end else begin
			acc_beats = acc_bytes;
		end
	end

	// Register bus: answer one cycle after the request, ack held for one cycle only
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h00000000;
		end else begin
			WB_ACK_OUT <= wb_req;
			WB_DAT_OUT <= 32'h00000000;
			if (wb_rd) begin
				case (WB_ADR_IN)
					`SDB_OFS_CTRL0: WB_DAT_OUT <= ctrl_q[0];
					`SDB_OFS_MASK0: WB_DAT_OUT <= mask_q[0];
					`SDB_OFS_CTRL1: WB_DAT_OUT <= ctrl_q[1];
					`SDB_OFS_MASK1: WB_DAT_OUT <= mask_q[1];
					`SDB_OFS_IRQ_STAT: WB_DAT_OUT <= {28'h0000000, irq_stat_q};
					`SDB_OFS_IRQ_MASK: WB_DAT_OUT <= {28'h0000000, irq_mask_q};
					default: WB_DAT_OUT <= 32'h00000000;
				endcase
			end
		end
	end

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_regs
			wire [7:0] ofs_c = (g == 0) ? `SDB_OFS_CTRL0 : `SDB_OFS_CTRL1;
			wire [7:0] ofs_m = (g == 0) ? `SDB_OFS_MASK0 : `SDB_OFS_MASK1;
			wire wr_c = wb_wr & (WB_ADR_IN == ofs_c);
			wire wr_m = wb_wr & (WB_ADR_IN == ofs_m);
			wire mine = (blk_q == g);
			wire [31:0] wmask = sel_mask & `SDB_CTRL_WMASK;
			wire [31:0] cnew = (ctrl_q[g] & ~wmask) | (WB_DAT_IN & wmask);
			always @(posedge CLK_IN or negedge RESET_N_IN) begin
				if (!RESET_N_IN) begin
					ctrl_q[g] <= `SDB_CTRL_RESET;
					mask_q[g] <= `SDB_MASK_RESET;
				end else begin
					// A trigger written in the same cycle as its self-clear survives
					ctrl_q[g] <= wr_c ? cnew : ctrl_q[g];
					if (mrs_done_q & mine & ~(wr_c & cnew[`SDB_CTRL_MODE_SET])) begin
						ctrl_q[g][`SDB_CTRL_MODE_SET] <= 1'b0;
					end
					if (precharge_all_cmd_done_q & mine & ~(wr_c & cnew[`SDB_CTRL_PRECHG])) begin
						ctrl_q[g][`SDB_CTRL_PRECHG] <= 1'b0;
					end
					if (wr_m) begin
						mask_q[g] <= (mask_q[g] & ~(sel_mask & `SDB_MASK_WMASK)) |
							(WB_DAT_IN & sel_mask & `SDB_MASK_WMASK);
					end
				end
			end
		end
	endgenerate

	// Sticky status, cleared by reading it; a new event in the read cycle is kept
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			irq_stat_q <= `SDB_IRQ_RESET;
			irq_mask_q <= `SDB_IRQ_RESET;
		end else begin
			irq_stat_q <= ((wb_rd && WB_ADR_IN == `SDB_OFS_IRQ_STAT) ? 4'h0 : irq_stat_q) |
				{acc_exc_q, addr_exc_q, precharge_all_cmd_done_q, mrs_done_q};
			if (wb_wr && WB_ADR_IN == `SDB_OFS_IRQ_MASK && WB_SEL_IN[0]) begin
				irq_mask_q <= WB_DAT_IN[3:0];
			end
		end
	end

	// The acknowledge comes from a pin, so it is synchronised first
	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ext_ack_s1_q <= 1'b0;
			ext_ack_s2_q <= 1'b0;
		end else begin
			ext_ack_s1_q <= EXT_ACK_IN;
			ext_ack_s2_q <= ext_ack_s1_q;
		end
	end

	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_q <= S_IDLE;
			blk_q <= 1'b0;
			we_q <= 1'b0;
			beats_q <= 5'h00;
			addr_q <= 32'h00000000;
			addr_step_q <= 3'h1;
			cmd_mrs_q <= 1'b0;
			close_then_open_q <= 1'b0;
			open_q <= 2'h0;
			row_q[0] <= {PW{1'b0}};
			row_q[1] <= {PW{1'b0}};
			ext_cnt_q <= 8'h00;
			mrs_done_q <= 1'b0;
			precharge_all_cmd_done_q <= 1'b0;
			addr_exc_q <= 1'b0;
			acc_exc_q <= 1'b0;
			ACC_DONE_OUT <= 1'b0;
			ACC_HIT_OUT <= 2'h0;
			EXT_CYC_OUT <= 1'b0;
			ADDR_EXC_OUT <= 1'b0;
			ACC_EXC_OUT <= 1'b0;
			SD_CS_N_OUT <= 2'h3;
			{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <= `SDB_CMD_NOP;
			SD_ADDR_OUT <= 32'h00000000;
			SD_DQ_OE_N_OUT <= 1'b1;
		end else begin
			mrs_done_q <= 1'b0;
			precharge_all_cmd_done_q <= 1'b0;
			addr_exc_q <= 1'b0;
			acc_exc_q <= 1'b0;
			ACC_DONE_OUT <= 1'b0;
			ADDR_EXC_OUT <= 1'b0;
			ACC_EXC_OUT <= 1'b0;
			SD_CS_N_OUT <= 2'h3;
			{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <= `SDB_CMD_NOP;
			SD_DQ_OE_N_OUT <= 1'b1;
			case (state_q)
				S_IDLE: begin
					if (take) begin
						blk_q <= hblk;
						we_q <= ACC_WE_IN;
						addr_q <= ACC_ADDR_IN;
						beats_q <= acc_beats;
						addr_step_q <= hctrl[`SDB_CTRL_PWS_HI] ? 3'h2 : 3'h1;
						ACC_HIT_OUT <= hit;
						if (hit == 2'h0) begin
							ACC_DONE_OUT <= 1'b1;
						end else if (ACC_WE_IN & hmask[`SDB_MASK_WP]) begin
							// Refused write never reaches the SDRAM pins
							ADDR_EXC_OUT <= 1'b1;
							addr_exc_q <= 1'b1;
							if (CS_HIT_IN) begin
								ACC_DONE_OUT <= 1'b1;
							end else begin
								EXT_CYC_OUT <= 1'b1;
								ext_cnt_q <= 8'h00;
								state_q <= S_EXT;
							end
						end else if (hctrl[`SDB_CTRL_MODE_SET]) begin
							cmd_mrs_q <= 1'b1;
							state_q <= S_CMD;
						end else if (hctrl[`SDB_CTRL_PRECHG] & ACC_WE_IN) begin
							cmd_mrs_q <= 1'b0;
							state_q <= S_CMD;
						end else if (open_q[hblk] && hctrl[`SDB_CTRL_PAGE] &&
							row_q[hblk] == acc_row) begin
							state_q <= S_XFER;
						end else if (open_q[hblk]) begin
							close_then_open_q <= 1'b1;
							state_q <= S_PRE;
						end else begin
							state_q <= S_ACT;
						end
					end
				end
				S_CMD: begin
					// Mode value rides on the address; data lanes stay undriven
					SD_CS_N_OUT[blk_q] <= 1'b0;
					SD_ADDR_OUT <= addr_q;
					if (cmd_mrs_q) begin
						{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <=
							`SDB_CMD_MRS;
						mrs_done_q <= 1'b1;
					end else begin
						{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <=
							`SDB_CMD_PRECHARGE_ALL_CMD;
						precharge_all_cmd_done_q <= 1'b1;
						open_q[blk_q] <= 1'b0;
					end
					ACC_DONE_OUT <= 1'b1;
					state_q <= S_IDLE;
				end
				S_ACT: begin
					SD_CS_N_OUT[blk_q] <= 1'b0;
					{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <= `SDB_CMD_ACT;
					SD_ADDR_OUT <= addr_q;
					open_q[blk_q] <= 1'b1;
					row_q[blk_q] <= addr_q[PAGE_MSB:PAGE_LSB];
					state_q <= S_XFER;
				end
				S_XFER: begin
					// One column command per port-wide beat of the transfer
					SD_CS_N_OUT[blk_q] <= 1'b0;
					{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <=
						we_q ? `SDB_CMD_WRITE : `SDB_CMD_READ;
					SD_ADDR_OUT <= addr_q;
					SD_DQ_OE_N_OUT <= ~we_q;
					addr_q <= addr_q + {29'h00000000, addr_step_q};
					beats_q <= beats_q - 5'h01;
					if (beats_q == 5'h01) begin
						if (cctrl[`SDB_CTRL_PAGE]) begin
							ACC_DONE_OUT <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							close_then_open_q <= 1'b0;
							state_q <= S_PRE;
						end
					end
				end
				S_PRE: begin
					SD_CS_N_OUT[blk_q] <= 1'b0;
					{SD_ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, SD_WE_N_OUT} <=
						`SDB_CMD_PRECHARGE_ALL_CMD;
					open_q[blk_q] <= 1'b0;
					if (close_then_open_q) begin
						close_then_open_q <= 1'b0;
						state_q <= S_ACT;
					end else begin
						ACC_DONE_OUT <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_EXT: begin
					// Bounded wait: a missing acknowledge must not hang the bus
					ext_cnt_q <= ext_cnt_q + 8'h01;
					if (ext_ack_s2_q) begin
						EXT_CYC_OUT <= 1'b0;
						ACC_DONE_OUT <= 1'b1;
						state_q <= S_IDLE;
					end else if (ext_cnt_q == `SDB_EXT_TIMEOUT - 8'h01) begin
						EXT_CYC_OUT <= 1'b0;
						ACC_EXC_OUT <= 1'b1;
						acc_exc_q <= 1'b1;
						ACC_DONE_OUT <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// *** hw/sdb_defs.vh ***
`ifndef SDB_DEFS_VH
`define SDB_DEFS_VH
// Overview of operation
// - Writing one to mode-set trigger turns the block's next access into mode set.
// - Controller clears the mode-set trigger itself once mode set has completed.
// - Mode-set access may read or write; data bus contents are ignored.
// - Port width field sizes accesses: upper bit one 16-bit, 01 8-bit.
// - With precharge trigger set, next write hitting the block issues precharge-all.
// - Controller clears the precharge trigger itself once precharge-all has finished.
// - Page policy clear: burst within page when wider than port, then precharge.
// - Page policy set: page stays open, same-page accesses assert only column strobe.
// - Each base mask bit one removes its address bit from the hit compare.
// - Write protect set: writes ignored and address exception raised.
// - Protected write goes to chip-select check; miss gives external cycle, no ack faults.
// - Access-type mask bits one keep their access type from hitting the block.
// - Valid bit zero stops any access hitting the block.
// - Hit only when every unmasked base bit equals the bus address bit.

// Register byte offsets
`define SDB_OFS_CTRL0 8'h00
`define SDB_OFS_MASK0 8'h04
`define SDB_OFS_CTRL1 8'h08
`define SDB_OFS_MASK1 8'h0C
`define SDB_OFS_IRQ_STAT 8'h10
`define SDB_OFS_IRQ_MASK 8'h14

// Control register fields
`define SDB_CTRL_BASE_HI 31
`define SDB_CTRL_BASE_LO 18
`define SDB_CTRL_MODE_SET 6
`define SDB_CTRL_PWS_HI 5
`define SDB_CTRL_PWS_LO 4
`define SDB_CTRL_PRECHG 3
`define SDB_CTRL_PAGE 2
// Writable bits: base, refresh enable, latency, mux select, triggers, width, page
`define SDB_CTRL_WMASK 32'hFFFCB77C
`define SDB_CTRL_RESET 32'h00000000

// Mask register fields
`define SDB_MASK_BASE_HI 31
`define SDB_MASK_BASE_LO 18
`define SDB_MASK_WP 8
`define SDB_MASK_TYPE_HI 6
`define SDB_MASK_TYPE_LO 1
`define SDB_MASK_VALID 0
`define SDB_MASK_WMASK 32'hFFFC017F
`define SDB_MASK_RESET 32'h00000000

// Interrupt status bits
`define SDB_IRQ_MRS_DONE 0
`define SDB_IRQ_PRECHARGE_ALL_CMD_DONE 1
`define SDB_IRQ_ADDR_EXC 2
`define SDB_IRQ_ACC_EXC 3
`define SDB_IRQ_RESET 4'h0

// SDRAM commands as {row strobe, column strobe, write enable}, active low
`define SDB_CMD_NOP 3'h7
`define SDB_CMD_ACT 3'h3
`define SDB_CMD_READ 3'h5
`define SDB_CMD_WRITE 3'h4
`define SDB_CMD_PRECHARGE_ALL_CMD 3'h2
`define SDB_CMD_MRS 3'h0

// Cycles an external bus cycle waits for its acknowledge
`define SDB_EXT_TIMEOUT 8'h40
`endif
